//--- hfc_pkg.sv
// hfc_pkg: offsets, field positions and reset values of the holdover
// frequency control registers.
// assumes a 32-bit apb slave, one register per aligned word.
package hfc_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_FREQ_LOW   = 8'h3e;
    localparam logic [7:0]  IDX_FREQ_MID   = 8'h3f;
    localparam logic [7:0]  IDX_MODE_CTRL  = 8'h40;
    localparam logic [11:0] ADDR_FREQ_LOW  = {2'h0, IDX_FREQ_LOW, 2'h0};
    localparam logic [11:0] ADDR_FREQ_MID  = {2'h0, IDX_FREQ_MID, 2'h0};
    localparam logic [11:0] ADDR_MODE_CTRL = {2'h0, IDX_MODE_CTRL, 2'h0};

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_AUTO_AVG   = 7;
    localparam int          BIT_FAST_AVG   = 6;
    localparam int          BIT_READ_AVG   = 5;
    localparam int          MINI_HI        = 4;
    localparam int          MINI_LO        = 3;
    localparam int          FREQ_TOP_HI    = 2;
    localparam int          FREQ_W         = 19;
    localparam logic [7:0]  RST_FREQ_LOW   = 8'h00;
    localparam logic [7:0]  RST_FREQ_MID   = 8'h00;
    localparam logic [7:0]  RST_MODE_CTRL  = 8'h88;

    // ------------------------------------------------------------
    // holdover frequency source
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HFC_SRC_MANUAL,
        HFC_SRC_FROZEN,
        HFC_SRC_AVG_FAST,
        HFC_SRC_AVG_SLOW
    } hfc_src_t;

endpackage

//--- hfc_regs.sv
// hfc_regs: apb register bank for the manual holdover frequency word and
// holdover mode control of the output timing loop.
// assumes averaged frequencies arrive from the averager on this clock.
//
// Functional notes
// - word is low byte, mid byte and mode bits [2:0] concatenated.
// - word is a signed two's complement offset from crystal frequency.
// - frequency registers writable; optionally read back averaged frequency.
// - mode control register read/write, resets to 0x88.
// - readback bit selects written value or fast/slow averaged value.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module hfc_regs #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // averager and holdover control
    input  wire logic signed [18:0]        avg_fast_freq,
    input  wire logic signed [18:0]        avg_slow_freq,
    input  wire logic                      manual_engage,
    output logic signed [18:0]             hold_freq_word,
    output var hfc_pkg::hfc_src_t          hold_src,
    output logic      [1:0]                mini_hold_mode
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 12) begin : g_chk
        $error("hfc_regs: ADDR_W must be at least 12");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  freq_low_reg,  freq_low_next;
    logic [7:0]  freq_mid_reg,  freq_mid_next;
    logic [7:0]  mode_ctrl_reg, mode_ctrl_next;
    logic [31:0] prdata_reg,    prdata_next;
    logic        slverr_reg,    slverr_next;
    logic        access;
    logic        hit_low, hit_mid, hit_mode;
    logic signed [18:0] avg_sel;

    assign access   = psel && penable;
    assign hit_low  = paddr == ADDR_W'(hfc_pkg::ADDR_FREQ_LOW);
    assign hit_mid  = paddr == ADDR_W'(hfc_pkg::ADDR_FREQ_MID);
    assign hit_mode = paddr == ADDR_W'(hfc_pkg::ADDR_MODE_CTRL);

    // averaged value chosen by the speed bit
    assign avg_sel = mode_ctrl_reg[hfc_pkg::BIT_FAST_AVG] ? avg_fast_freq
                                                          : avg_slow_freq;

    // next register values; one-wait slave, every access completes one cycle after the access phase starts
    always_comb begin
        freq_low_next  = freq_low_reg;
        freq_mid_next  = freq_mid_reg;
        mode_ctrl_next = mode_ctrl_reg;
        prdata_next    = prdata_reg;
        slverr_next    = 1'b0;
        if (access && pwrite) begin
            // byte lane 0 only carries data; other lanes ignored
            if (hit_low) begin
                if (pstrb[0]) freq_low_next = pwdata[7:0];
            end else if (hit_mid) begin
                if (pstrb[0]) freq_mid_next = pwdata[7:0];
            end else if (hit_mode) begin
                if (pstrb[0]) mode_ctrl_next = pwdata[7:0];
            end else begin
                slverr_next = 1'b1;
            end
        end else if (access) begin
            prdata_next = 32'h0000_0000;
            // read_average swaps in the averager output
            if (hit_low) begin
                prdata_next[7:0] = mode_ctrl_reg[hfc_pkg::BIT_READ_AVG]
                                   ? avg_sel[7:0] : freq_low_reg;
            end else if (hit_mid) begin
                prdata_next[7:0] = mode_ctrl_reg[hfc_pkg::BIT_READ_AVG]
                                   ? avg_sel[15:8] : freq_mid_reg;
            end else if (hit_mode) begin
                prdata_next[7:0] = mode_ctrl_reg;
                if (mode_ctrl_reg[hfc_pkg::BIT_READ_AVG]) begin
                    prdata_next[2:0] = avg_sel[18:16];
                end
            end else begin
                slverr_next = 1'b1;
            end
        end
    end

    // register update
    always_ff @(posedge clk) begin
        if (!rstn) begin
            freq_low_reg  <= hfc_pkg::RST_FREQ_LOW;
            freq_mid_reg  <= hfc_pkg::RST_FREQ_MID;
            mode_ctrl_reg <= hfc_pkg::RST_MODE_CTRL;
            prdata_reg    <= 32'h0000_0000;
            slverr_reg    <= 1'b0;
        end else begin
            freq_low_reg  <= freq_low_next;
            freq_mid_reg  <= freq_mid_next;
            mode_ctrl_reg <= mode_ctrl_next;
            prdata_reg    <= prdata_next;
            slverr_reg    <= slverr_next;
        end
    end

    // read data is registered, so answer one cycle after the access phase
    // starts; pready held low in that first access cycle
    logic ack_reg, ack_next;
    always_comb begin
        ack_next = access && !ack_reg;
    end
    always_ff @(posedge clk) begin
        if (!rstn) ack_reg <= 1'b0;
        else       ack_reg <= ack_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready  = ack_reg;
    assign prdata  = prdata_reg;
    assign pslverr = slverr_reg && ack_reg;

    // signed word straight from the three fields
    assign hold_freq_word = {mode_ctrl_reg[hfc_pkg::FREQ_TOP_HI:0],
                             freq_mid_reg, freq_low_reg};
    assign mini_hold_mode = mode_ctrl_reg[hfc_pkg::MINI_HI:hfc_pkg::MINI_LO];

    // source select; manual engagement beats averaging
    always_comb begin
        if (manual_engage)
            hold_src = hfc_pkg::HFC_SRC_MANUAL;
        else if (!mode_ctrl_reg[hfc_pkg::BIT_AUTO_AVG])
            hold_src = hfc_pkg::HFC_SRC_FROZEN;
        else if (mode_ctrl_reg[hfc_pkg::BIT_FAST_AVG])
            hold_src = hfc_pkg::HFC_SRC_AVG_FAST;
        else
            hold_src = hfc_pkg::HFC_SRC_AVG_SLOW;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_write_mid;
        psel && penable && pwrite && hit_mid && pstrb[0] && !ack_reg;
    endsequence

    sequence s_write_low;
        psel && penable && pwrite && hit_low && pstrb[0] && !ack_reg;
    endsequence

    sequence s_write_mode;
        psel && penable && pwrite && hit_mode && pstrb[0] && !ack_reg;
    endsequence

    // written low byte must appear in the bottom of the word
    property p_word_concat;
        @(posedge clk) disable iff (!rstn)
        s_write_low |=> hold_freq_word[7:0] == $past(pwdata[7:0]);
    endproperty
    a_word_concat: assert property (p_word_concat)
        else $error("holdover word not the field concatenation");

    // mode bit 2 written high must make the word negative
    property p_sign;
        @(posedge clk) disable iff (!rstn)
        s_write_mode |=> (hold_freq_word < 19'sh0) == $past(pwdata[2]);
    endproperty
    a_sign: assert property (p_sign)
        else $error("holdover word sign bit wrong");

    property p_mid_write;
        @(posedge clk) disable iff (!rstn)
        s_write_mid |=> freq_mid_reg == $past(pwdata[7:0]);
    endproperty
    a_mid_write: assert property (p_mid_write)
        else $error("mid byte write lost");

    property p_reset_mode;
        @(posedge clk) !rstn |=> mode_ctrl_reg == hfc_pkg::RST_MODE_CTRL;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("mode control reset value wrong");

    property p_manual_wins;
        @(posedge clk) disable iff (!rstn)
        manual_engage |-> hold_src == hfc_pkg::HFC_SRC_MANUAL;
    endproperty
    a_manual_wins: assert property (p_manual_wins)
        else $error("manual holdover not overriding");

    property p_no_avg;
        @(posedge clk) disable iff (!rstn)
        (!manual_engage && !mode_ctrl_reg[7])
            |-> hold_src == hfc_pkg::HFC_SRC_FROZEN;
    endproperty
    a_no_avg: assert property (p_no_avg)
        else $error("averaged source used with averaging off");

    property p_read_written;
        @(posedge clk) disable iff (!rstn)
        (access && !pwrite && hit_mid && !ack_reg && !mode_ctrl_reg[5])
            |=> pready && prdata[7:0] == $past(freq_mid_reg);
    endproperty
    a_read_written: assert property (p_read_written)
        else $error("written value not read back");

    property p_read_avg;
        @(posedge clk) disable iff (!rstn)
        (access && !pwrite && hit_low && !ack_reg && mode_ctrl_reg[5])
            |=> pready && prdata[7:0] == $past(avg_sel[7:0]);
    endproperty
    a_read_avg: assert property (p_read_avg)
        else $error("averaged value not read back");

    property p_answer_time;
        @(posedge clk) disable iff (!rstn)
        (psel && penable && !ack_reg) |=> pready ##1 !pready;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("apb answer not one cycle");

endmodule

`default_nettype wire

//--- hfc_regs_bench.sv
// hfc_regs_bench: self-checking bench for the holdover frequency registers.
// assumes hfc_regs answers apb within a few cycles and carries its checks.
`timescale 1ns/10ps
`default_nettype none

module hfc_regs_bench;

    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic                    clk, rstn, psel, penable, pwrite;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata;
    logic [3:0]              pstrb;
    logic                    pready, pslverr, manual_engage;
    logic signed [18:0]      avg_fast_freq, avg_slow_freq, hold_freq_word;
    hfc_pkg::hfc_src_t       hold_src;
    logic [1:0]              mini_hold_mode;
    logic [33:0]             exp_q[$]; // {check data, slverr, data}
    logic [33:0]             note;
    logic [18:0]             w, av;
    hfc_pkg::hfc_src_t       src_e;
    int                      fails, checks_done;

    hfc_regs u_hfc_regs (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .avg_fast_freq(avg_fast_freq), .avg_slow_freq(avg_slow_freq),
        .manual_engage(manual_engage), .hold_freq_word(hold_freq_word),
        .hold_src(hold_src), .mini_hold_mode(mini_hold_mode));

    // ------------------------------------------------------------
    // clock, compare and closing
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // apb master; one idle cycle after each transfer
    // ------------------------------------------------------------
    task automatic xfer(input logic is_wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s,
                        input logic [33:0] n);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        exp_q.push_back(n);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d}, 4'h1, 34'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0, 4'h0, {2'b10, 24'h0, e});
    endtask

    // monitor: the oldest note is judged at every completed transfer
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            note = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (note[33])
                check("prdata", prdata, note[31:0]);
        end
    end

    // watchdog sized well beyond the sequence below
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        summarize;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, manual_engage} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        avg_fast_freq = 19'sh0;
        avg_slow_freq = 19'sh0;
        rstn = 1'b0;
        void'($urandom(58));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("src", {30'h0, hold_src},
              {30'h0, hfc_pkg::HFC_SRC_AVG_SLOW});
        check("mini", {30'h0, mini_hold_mode}, 32'h1);
        @(posedge clk);
        rd(hfc_pkg::ADDR_MODE_CTRL, 8'h88);
        rd(hfc_pkg::ADDR_FREQ_MID, 8'h00);
        // software writes back a filtered report word in the same format
        w = 19'($urandom);
        wr(hfc_pkg::ADDR_FREQ_LOW, w[7:0]);
        wr(hfc_pkg::ADDR_FREQ_MID, w[15:8]);
        wr(hfc_pkg::ADDR_MODE_CTRL, {5'h11, w[18:16]});
        check("word", {13'h0, hold_freq_word}, {13'h0, w});
        check("sign", {31'h0, hold_freq_word < 0}, {31'h0, w[18]});
        rd(hfc_pkg::ADDR_FREQ_MID, w[15:8]);
        // strobe lane clear: no write; unmapped: error, nothing stored
        xfer(1'b1, hfc_pkg::ADDR_FREQ_LOW, {24'h0, ~w[7:0]}, 4'h0,
             34'h0);
        rd(hfc_pkg::ADDR_FREQ_LOW, w[7:0]);
        xfer(1'b1, 12'h104, 32'hff, 4'h1, {2'b01, 32'h0});
        xfer(1'b0, 12'h104, 32'h0, 4'h0, {2'b01, 32'h0});
        // readback of fast and slow averages, written value kept
        for (int f = 0; f < 2; f++) begin
            av = 19'($urandom);
            avg_fast_freq <= f ? av : ~av;
            avg_slow_freq <= f ? ~av : av;
            wr(hfc_pkg::ADDR_MODE_CTRL, {2'b10 | 2'(f), 3'h6, w[18:16]});
            rd(hfc_pkg::ADDR_FREQ_LOW, av[7:0]);
            rd(hfc_pkg::ADDR_FREQ_MID, av[15:8]);
            rd(hfc_pkg::ADDR_MODE_CTRL,
               {2'b10 | 2'(f), 3'h6, av[18:16]});
            check("mini", {30'h0, mini_hold_mode}, 32'h2);
            check("word kept", {13'h0, hold_freq_word}, {13'h0, w});
        end
        // every combination of averaging use, speed and manual engage
        for (int i = 0; i < 8; i++) begin
            manual_engage <= i[0];
            wr(hfc_pkg::ADDR_MODE_CTRL, {i[2], i[1], 6'h08});
            src_e = i[0] ? hfc_pkg::HFC_SRC_MANUAL : !i[2] ?
                hfc_pkg::HFC_SRC_FROZEN : i[1] ? hfc_pkg::HFC_SRC_AVG_FAST :
                hfc_pkg::HFC_SRC_AVG_SLOW;
            check("src", {30'h0, hold_src}, {30'h0, src_e});
        end
        rd(hfc_pkg::ADDR_FREQ_LOW, w[7:0]);
        summarize;
    end

endmodule
`default_nettype wire
